// ### pio_ports.sv
// Purpose: five parallel io ports (a..e), 33 pins, with direction, pullup and peripheral takeover
// Assumes: one clock, 8-bit register port with one-cycle read data
// Notes: pins are sampled through three flops before software sees them
//
// Functional notes
// R1 - thirty-three two-way pins in ports a to e
// R2 - each pin set as input or output by software
// R3 - ports a, c, d have pullup enables, active only for inputs
// R4 - output direction disables the pullup whatever its enable says
// R5 - data latches keep their value through reset
// R6 - port a direction at 0x0004, eight bits, reset zero
// R7 - port b direction at 0x0005, eight bits, reset zero
// R8 - port c data holds bits 6..0, bit 7 reads zero
// R9 - port c direction bits 6..0, reset zero, bit 7 reads zero
// R10 - port d direction eight bits, reset zero
// R11 - port e data bits 1..0 only, others zero, no reset
// R12 - port e direction bits 1..0, reset zero, others read zero
// R13 - port a pullup enable eight bits, reset zero
// R14 - port c pullup enable bits 6..0, reset zero, bit 7 zero
// R15 - port d pullup enable eight bits, reset zero
// R16 - peripheral enables take pins away from the port logic
// R17 - data read gives latch for outputs, pin level for inputs
// R18 - data writes always update the latch
// R19 - direction one drives the pin, zero releases it
// R20 - selected adc channel pin forced to analog input
// R21 - one-cycle accesses, new values act on the next edge
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pio_ports (
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [3:0] addr, // register offset
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire logic [7:0] port_a_in, // port a pin levels
    output logic [7:0] port_a_out, // port a drive value
    output logic [7:0] port_a_oe, // port a drive enable
    output logic [7:0] port_a_pullup, // port a pullup on
    input wire logic [7:0] port_b_in, // port b pin levels
    output logic [7:0] port_b_out, // port b drive value
    output logic [7:0] port_b_oe, // port b drive enable
    output logic [7:0] port_b_analog, // port b pin given to adc
    input wire logic [6:0] port_c_in, // port c pin levels
    output logic [6:0] port_c_out, // port c drive value
    output logic [6:0] port_c_oe, // port c drive enable
    output logic [6:0] port_c_pullup, // port c pullup on
    input wire logic [7:0] port_d_in, // port d pin levels
    output logic [7:0] port_d_out, // port d drive value
    output logic [7:0] port_d_oe, // port d drive enable
    output logic [7:0] port_d_pullup, // port d pullup on
    input wire logic [1:0] port_e_in, // port e pin levels
    output logic [1:0] port_e_out, // port e drive value
    output logic [1:0] port_e_oe, // port e drive enable
    input wire logic [7:0] keypad_pin_enables, // keypad owns port a bit
    input wire logic [4:0] analog_channel_select, // adc channel, 0..7 on port b
    input wire logic serial_periph_enable, // spi owns port d 3..0
    input wire logic [1:0] timer_ch0_edge_level_select_first, // first timer ch0, pin d4
    input wire logic [1:0] timer_ch1_edge_level_select_first, // first timer ch1, pin d5
    input wire logic [1:0] timer_ch0_edge_level_select_second, // second timer ch0, pin d6
    input wire logic [1:0] timer_ch1_edge_level_select_second, // second timer ch1, pin d7
    input wire logic async_serial_enable, // serial interface owns port e
    output logic [7:0] port_a_periph_owned, // port a taken by keypad
    output logic [7:0] port_d_periph_owned, // port d taken by spi or timers
    output logic [1:0] port_e_periph_owned, // port e taken by serial
    output logic [7:0] keypad_inputs // synchronised port a levels for keypad
);
    logic [7:0] port_a_data;
    logic [7:0] port_b_data;
    logic [6:0] port_c_data;
    logic [7:0] port_d_data;
    logic [1:0] port_e_data;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [6:0] port_c_direction;
    logic [7:0] port_d_direction;
    logic [1:0] port_e_direction;
    logic [7:0] port_a_pullup_enable;
    logic [6:0] port_c_pullup_enable;
    logic [7:0] port_d_pullup_enable;
    logic [32:0] pin_s1;
    logic [32:0] pin_s2;
    logic [32:0] pin_s3;
    logic [32:0] pin_level;
    logic [7:0] next_rdata;
    logic [7:0] next_analog;
    logic [7:0] next_d_owned;

    // latch for outputs, debounced level for inputs
    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] pin);
        port_read = (dir & latch) | (~dir & pin); // R17
    endfunction

    // three-stage sampler; a level counts when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 33'h0_0000_0000;
            pin_s2 <= 33'h0_0000_0000;
            pin_s3 <= 33'h0_0000_0000;
        end else begin
            pin_s1 <= {port_e_in, port_d_in, port_c_in, port_b_in, port_a_in}; // R1
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_level <= 33'h0_0000_0000;
        end else begin
            pin_level <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_level & (pin_s2 ^ pin_s3));
        end
    end

    // no reset: latches hold their contents across reset
    always_ff @(posedge clk) begin
        if (wr) begin
            unique case (addr) // R5 R18 R21
                pio_pkg::OFS_PORT_A_DATA: port_a_data <= wdata;
                pio_pkg::OFS_PORT_B_DATA: port_b_data <= wdata;
                pio_pkg::OFS_PORT_C_DATA: port_c_data <= wdata[6:0]; // R8
                pio_pkg::OFS_PORT_D_DATA: port_d_data <= wdata;
                pio_pkg::OFS_PORT_E_DATA: port_e_data <= wdata[1:0]; // R11
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_a_direction <= pio_pkg::DIRECTION_RESET; // R6
            port_b_direction <= pio_pkg::DIRECTION_RESET; // R7
            port_c_direction <= pio_pkg::DIRECTION_RESET[6:0]; // R9
            port_d_direction <= pio_pkg::DIRECTION_RESET; // R10
            port_e_direction <= pio_pkg::DIRECTION_RESET[1:0]; // R12
        end else if (wr) begin
            unique case (addr) // R2 R21
                pio_pkg::OFS_PORT_A_DIRECTION: port_a_direction <= wdata;
                pio_pkg::OFS_PORT_B_DIRECTION: port_b_direction <= wdata;
                pio_pkg::OFS_PORT_C_DIRECTION: port_c_direction <= wdata[6:0];
                pio_pkg::OFS_PORT_D_DIRECTION: port_d_direction <= wdata;
                pio_pkg::OFS_PORT_E_DIRECTION: port_e_direction <= wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_a_pullup_enable <= pio_pkg::PULLUP_RESET; // R13
            port_c_pullup_enable <= pio_pkg::PULLUP_RESET[6:0]; // R14
            port_d_pullup_enable <= pio_pkg::PULLUP_RESET; // R15
        end else if (wr) begin
            unique case (addr) // R3
                pio_pkg::OFS_PORT_A_PULLUP_ENABLE: port_a_pullup_enable <= wdata;
                pio_pkg::OFS_PORT_C_PULLUP_ENABLE: port_c_pullup_enable <= wdata[6:0];
                pio_pkg::OFS_PORT_D_PULLUP_ENABLE: port_d_pullup_enable <= wdata;
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets 9..b read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr)
            pio_pkg::OFS_PORT_A_DATA: next_rdata = port_read(port_a_direction, port_a_data, pin_level[7:0]);
            pio_pkg::OFS_PORT_B_DATA: next_rdata = port_read(port_b_direction, port_b_data, pin_level[15:8]);
            pio_pkg::OFS_PORT_C_DATA: next_rdata = pio_pkg::MASK_PORT_C & port_read({1'b0, port_c_direction},
                                                   {1'b0, port_c_data}, {1'b0, pin_level[22:16]}); // R8
            pio_pkg::OFS_PORT_D_DATA: next_rdata = port_read(port_d_direction, port_d_data, pin_level[30:23]);
            pio_pkg::OFS_PORT_A_DIRECTION: next_rdata = port_a_direction;
            pio_pkg::OFS_PORT_B_DIRECTION: next_rdata = port_b_direction;
            pio_pkg::OFS_PORT_C_DIRECTION: next_rdata = {1'b0, port_c_direction}; // R9
            pio_pkg::OFS_PORT_D_DIRECTION: next_rdata = port_d_direction;
            pio_pkg::OFS_PORT_E_DATA: next_rdata = pio_pkg::MASK_PORT_E & port_read({6'h00, port_e_direction},
                                                   {6'h00, port_e_data}, {6'h00, pin_level[32:31]}); // R11
            pio_pkg::OFS_PORT_E_DIRECTION: next_rdata = {6'h00, port_e_direction}; // R12
            pio_pkg::OFS_PORT_A_PULLUP_ENABLE: next_rdata = port_a_pullup_enable;
            pio_pkg::OFS_PORT_C_PULLUP_ENABLE: next_rdata = {1'b0, port_c_pullup_enable}; // R14
            pio_pkg::OFS_PORT_D_PULLUP_ENABLE: next_rdata = port_d_pullup_enable;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata; // R21
        end else begin
            rdata <= 8'h00;
        end
    end

    // peripheral ownership decode
    always_comb begin
        next_analog = 8'h00;
        if (analog_channel_select < pio_pkg::ADC_CHANNEL_COUNT) begin
            next_analog[analog_channel_select[2:0]] = 1'b1; // R20
        end
        next_d_owned = 8'h00;
        next_d_owned[pio_pkg::SPI_PIN_LO +: 4] = {4{serial_periph_enable}}; // R16
        next_d_owned[pio_pkg::TIMER_PIN_LO + 0] = |timer_ch0_edge_level_select_first;
        next_d_owned[pio_pkg::TIMER_PIN_LO + 1] = |timer_ch1_edge_level_select_first;
        next_d_owned[pio_pkg::TIMER_PIN_LO + 2] = |timer_ch0_edge_level_select_second;
        next_d_owned[pio_pkg::TIMER_PIN_LO + 3] = |timer_ch1_edge_level_select_second;
    end

    // pin drive registered so every output leaves a flop; one edge of latency
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_a_out <= 8'h00;
            port_a_oe <= 8'h00;
            port_a_pullup <= 8'h00;
            port_b_out <= 8'h00;
            port_b_oe <= 8'h00;
            port_b_analog <= 8'h00;
            port_c_out <= 7'h00;
            port_c_oe <= 7'h00;
            port_c_pullup <= 7'h00;
            port_d_out <= 8'h00;
            port_d_oe <= 8'h00;
            port_d_pullup <= 8'h00;
            port_e_out <= 2'h0;
            port_e_oe <= 2'h0;
            port_a_periph_owned <= 8'h00;
            port_d_periph_owned <= 8'h00;
            port_e_periph_owned <= 2'h0;
            keypad_inputs <= 8'h00;
        end else begin
            port_a_out <= port_a_data;
            port_a_oe <= port_a_direction & ~keypad_pin_enables; // R16 R19
            port_a_pullup <= port_a_pullup_enable & ~port_a_direction; // R3 R4
            port_b_out <= port_b_data;
            port_b_oe <= port_b_direction & ~next_analog; // R19 R20
            port_b_analog <= next_analog; // R20
            port_c_out <= port_c_data;
            port_c_oe <= port_c_direction; // R19
            port_c_pullup <= port_c_pullup_enable & ~port_c_direction; // R3 R4
            port_d_out <= port_d_data;
            port_d_oe <= port_d_direction & ~next_d_owned; // R16 R19
            port_d_pullup <= port_d_pullup_enable & ~port_d_direction; // R3 R4
            port_e_out <= port_e_data;
            port_e_oe <= port_e_direction & ~{2{async_serial_enable}}; // R16 R19
            port_a_periph_owned <= keypad_pin_enables; // R16
            port_d_periph_owned <= next_d_owned;
            port_e_periph_owned <= {2{async_serial_enable}};
            keypad_inputs <= pin_level[7:0];
        end
    end
endmodule // pio_ports
`default_nettype wire

// ### pio_pkg.sv
// Purpose: shared constants for the parallel io port block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: data latches have no reset value
package pio_pkg;
    localparam logic [3:0] OFS_PORT_A_DATA = 4'h0;
    localparam logic [3:0] OFS_PORT_B_DATA = 4'h1;
    localparam logic [3:0] OFS_PORT_C_DATA = 4'h2;
    localparam logic [3:0] OFS_PORT_D_DATA = 4'h3;
    localparam logic [3:0] OFS_PORT_A_DIRECTION = 4'h4;
    localparam logic [3:0] OFS_PORT_B_DIRECTION = 4'h5;
    localparam logic [3:0] OFS_PORT_C_DIRECTION = 4'h6;
    localparam logic [3:0] OFS_PORT_D_DIRECTION = 4'h7;
    localparam logic [3:0] OFS_PORT_E_DATA = 4'h8;
    localparam logic [3:0] OFS_PORT_E_DIRECTION = 4'hc;
    localparam logic [3:0] OFS_PORT_A_PULLUP_ENABLE = 4'hd;
    localparam logic [3:0] OFS_PORT_C_PULLUP_ENABLE = 4'he;
    localparam logic [3:0] OFS_PORT_D_PULLUP_ENABLE = 4'hf;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] MASK_PORT_C = 8'h7f;
    localparam logic [7:0] MASK_PORT_E = 8'h03;
    localparam int SPI_PIN_LO = 0;
    localparam int TIMER_PIN_LO = 4;
    localparam logic [4:0] ADC_CHANNEL_COUNT = 5'h08;
endpackage

// ### pio_ports_asserts.sv
// Purpose: port-level assertions for pio_ports
// Assumes: single clock, rst_b async active low
// Notes: peripheral masks judged once their control has held two cycles
`timescale 1ns/1ps
`default_nettype none
module pio_ports_chk (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic [3:0] addr, // offset
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [7:0] rdata, // read data
    input wire logic [7:0] port_a_out, // a drive
    input wire logic [7:0] port_a_oe, // a enable
    input wire logic [7:0] port_a_pullup, // a pullup
    input wire logic [7:0] port_b_oe, // b enable
    input wire logic [7:0] port_b_analog, // b analog
    input wire logic [7:0] port_d_oe, // d enable
    input wire logic [7:0] port_d_pullup, // d pullup
    input wire logic [1:0] port_e_oe, // e enable
    input wire logic [7:0] keypad_pin_enables, // keypad
    input wire logic [4:0] analog_channel_select, // adc
    input wire logic async_serial_enable // serial
);
    logic [7:0] kp_q;
    logic [4:0] sel_q;
    logic se_q;
    always_ff @(posedge clk) begin
        kp_q <= keypad_pin_enables;
        sel_q <= analog_channel_select;
        se_q <= async_serial_enable;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not zero");
    chk_dir_readback: assert property (
        wr && addr == 4'h4 ##1 rd && addr == 4'h4 |=> rdata == $past(wdata, 2)) else $error("dir readback");
    chk_latch_out: assert property (
        wr && addr == 4'h0 ##1 !(wr && addr == 4'h0) |=> port_a_out == $past(wdata, 2)) else $error("latch out");
    chk_pullup_off: assert property (
        ((port_a_pullup & port_a_oe) | (port_d_pullup & port_d_oe)) == 8'h00) else $error("pullup on output");
    chk_keypad_mask: assert property (
        keypad_pin_enables == kp_q |=> (port_a_oe & kp_q) == 8'h00) else $error("keypad pin driven");
    chk_adc_onehot: assert property (analog_channel_select == sel_q |=>
        port_b_analog == (sel_q < 5'h08 ? 8'h01 << sel_q : 8'h00) && (port_b_oe & port_b_analog) == 8'h00)
        else $error("adc pin select");
    chk_serial_off: assert property (async_serial_enable && se_q |=> port_e_oe == 2'b00) else $error("e driven");
    chk_reset_clear: assert property ($rose(rst_b) |->
        port_a_oe == 8'h00 && port_a_pullup == 8'h00 && port_d_pullup == 8'h00) else $error("reset values");
    chk_c_bit7: assert property (
        rd && addr inside {4'h2, 4'h6, 4'he} |=> rdata[7] == 1'b0) else $error("c bit 7 set");
    chk_e_high: assert property (
        rd && addr inside {4'h8, 4'hc} |=> rdata[7:2] == 6'h00) else $error("e high bits set");
    cover property (wr && addr == 4'h4 ##1 rd && addr == 4'h4);
    cover property (async_serial_enable && se_q);
    cover property (analog_channel_select == sel_q && sel_q < 5'h08);
endmodule // pio_ports_chk
bind pio_ports pio_ports_chk pio_ports_chk_i (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .port_a_out, .port_a_oe,
    .port_a_pullup, .port_b_oe, .port_b_analog, .port_d_oe, .port_d_pullup, .port_e_oe, .keypad_pin_enables,
    .analog_channel_select, .async_serial_enable);
`default_nettype wire

// ### pio_pin_model.sv
// Purpose: pins and outside world of one port
// Assumes: outside driver is strong whenever present
// Notes: released unpulled pins toggle so a stale level cannot pass
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model #(
    parameter int W = 8
) (
    input wire logic clk, // clock
    input wire logic [W-1:0] out, // device drive value
    input wire logic [W-1:0] oe, // device drive enable
    input wire logic [W-1:0] pull, // device pullup
    input wire logic ext_on, // outside driver present
    input wire logic [W-1:0] val, // outside drive value
    output logic [W-1:0] level // resolved pin level
);
    logic pat = 1'b0;
    always_ff @(posedge clk) pat <= ~pat;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) level[i] = out[i];
            else if (ext_on) level[i] = val[i];
            else if (pull[i]) level[i] = 1'b1;
            else level[i] = pat;
        end
    end
endmodule // pio_pin_model
`default_nettype wire

// ### parallel_io_ports_tb.sv
// Purpose: self-checking bench for pio_ports
// Assumes: register port with read data in the cycle after rd
// Notes: m mirrors registers, pin holds outside levels
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_tb;
    logic clk, rst_b, wr, rd, serial_periph_enable, async_serial_enable, ext_a, ext_r;
    logic [7:0] port_a_periph_owned, port_d_periph_owned, keypad_inputs, d_exp;
    logic [1:0] port_e_periph_owned;
    logic [3:0] addr;
    logic [4:0] analog_channel_select;
    logic [7:0] wdata, rdata, port_a_in, port_a_out, port_a_oe, port_a_pullup, port_b_in, port_b_out, port_b_oe;
    logic [7:0] port_b_analog, port_d_in, port_d_out, port_d_oe, port_d_pullup, keypad_pin_enables, seed_b;
    logic [6:0] port_c_in, port_c_out, port_c_oe, port_c_pullup;
    logic [1:0] port_e_in, port_e_out, port_e_oe, timer_ch0_edge_level_select_first, timer_ch1_edge_level_select_first;
    logic [1:0] timer_ch0_edge_level_select_second, timer_ch1_edge_level_select_second;
    logic [7:0] m [16];
    logic [7:0] pin [16];
    logic [31:0] seed = 32'h2ae9_4081;
    int n_mismatch = 0;
    int tests_run = 0;
    pio_ports pio_ports_i (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .port_a_in, .port_a_out, .port_a_oe,
        .port_a_pullup, .port_b_in, .port_b_out, .port_b_oe, .port_b_analog, .port_c_in, .port_c_out, .port_c_oe,
        .port_c_pullup, .port_d_in, .port_d_out, .port_d_oe, .port_d_pullup, .port_e_in, .port_e_out, .port_e_oe,
        .keypad_pin_enables, .analog_channel_select, .serial_periph_enable, .timer_ch0_edge_level_select_first,
        .timer_ch1_edge_level_select_first, .timer_ch0_edge_level_select_second, .timer_ch1_edge_level_select_second,
        .async_serial_enable, .port_a_periph_owned, .port_d_periph_owned, .port_e_periph_owned, .keypad_inputs);
    pio_pin_model #(.W(8)) pio_pin_model_a_i (.clk, .out(port_a_out), .oe(port_a_oe), .pull(port_a_pullup),
        .ext_on(ext_a), .val(pin[0]), .level(port_a_in));
    pio_pin_model #(.W(8)) pio_pin_model_b_i (.clk, .out(port_b_out), .oe(port_b_oe), .pull(8'h00),
        .ext_on(ext_r), .val(pin[1]), .level(port_b_in));
    pio_pin_model #(.W(7)) pio_pin_model_c_i (.clk, .out(port_c_out), .oe(port_c_oe), .pull(port_c_pullup),
        .ext_on(ext_r), .val(pin[2][6:0]), .level(port_c_in));
    pio_pin_model #(.W(8)) pio_pin_model_d_i (.clk, .out(port_d_out), .oe(port_d_oe), .pull(port_d_pullup),
        .ext_on(ext_r), .val(pin[3]), .level(port_d_in));
    pio_pin_model #(.W(2)) pio_pin_model_e_i (.clk, .out(port_e_out), .oe(port_e_oe), .pull(2'b00),
        .ext_on(ext_r), .val(pin[8][1:0]), .level(port_e_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] rmask(input logic [3:0] a);
        case (a)
            4'h2, 4'h6, 4'he: return 8'h7f;
            4'h8, 4'hc: return 8'h03;
            4'h9, 4'ha, 4'hb: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        logic [7:0] d;
        d = m[(a == 4'h8) ? 4'hc : a + 4'h4];
        if (a < 4'h4 || a == 4'h8) return ((m[a] & d) | (pin[a] & ~d)) & rmask(a);
        return m[a] & rmask(a);
    endfunction
    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobe left high so back-to-back writes never assign wr twice in one step
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        m[a] = d & rmask(a);
    endtask
    task automatic rd_chk(input logic [3:0] a);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("rdata", exp_rd(a), rdata);
        @(posedge clk);
    endtask
    task automatic chk_pins;
        wr <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("a_oe", m[4], port_a_oe);
        chk("b_oe", m[5], port_b_oe);
        chk("a_pu", m[13] & ~m[4], port_a_pullup);
        chk("a_out", m[0], port_a_out);
        chk("c_pu", m[14] & ~m[6], {1'b0, port_c_pullup});
        chk("d_pu", m[15] & ~m[7], port_d_pullup);
        chk("e_oe", m[12], {6'h00, port_e_oe});
        chk("c_oe", m[6], {1'b0, port_c_oe});
        chk("d_oe", m[7], port_d_oe);
        chk("b_out", m[1], port_b_out);
        chk("c_out", m[2], {1'b0, port_c_out});
        chk("d_out", m[3], port_d_out);
        chk("e_out", m[8], {6'h00, port_e_out});
        @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
    initial begin
        {wr, rd, addr, wdata, keypad_pin_enables, serial_periph_enable, async_serial_enable} = '0;
        {timer_ch0_edge_level_select_first, timer_ch1_edge_level_select_first} = '0;
        {timer_ch0_edge_level_select_second, timer_ch1_edge_level_select_second} = '0;
        analog_channel_select = 5'h1f;
        rst_b = 1'b0;
        ext_a = 1'b1;
        ext_r = 1'b1;
        for (int i = 0; i < 16; i++) begin
            m[i] = 8'h00;
            pin[i] = 8'h00;
        end
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 4; a < 16; a++) rd_chk(4'(a));
        wr_reg(4'h4, 8'ha5);
        rd_chk(4'h4);
        for (int k = 0; k < 20; k++) begin
            for (int a = 0; a < 16; a++) begin
                seed = xs(seed);
                wr_reg(4'(a), seed[7:0]);
                pin[a] <= seed[15:8];
            end
            chk_pins;
            for (int a = 0; a < 16; a++) rd_chk(4'(a));
        end
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // port e latch at 0x8 keeps its value through reset
        for (int a = 4; a < 16; a++) if (a != 8) m[a] = 8'h00;
        chk_pins;
        ext_a <= 1'b0;
        ext_r <= 1'b0;
        pin[0] <= 8'hff;
        pin[2] <= 8'hff;
        pin[3] <= 8'hff;
        wr_reg(4'hd, 8'hff);
        wr_reg(4'he, 8'hff);
        wr_reg(4'hf, 8'hff);
        chk_pins;
        rd_chk(4'h0);
        rd_chk(4'h2);
        rd_chk(4'h3);
        ext_a <= 1'b1;
        ext_r <= 1'b1;
        for (int a = 4; a < 13; a++) wr_reg(4'(a), 8'hff);
        chk_pins;
        for (int a = 0; a < 16; a++) rd_chk(4'(a));
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            seed_b = seed[15:8];
            keypad_pin_enables <= seed[7:0];
            analog_channel_select <= 5'(i);
            {timer_ch0_edge_level_select_first, timer_ch1_edge_level_select_first} <= seed_b[7:4];
            {timer_ch0_edge_level_select_second, timer_ch1_edge_level_select_second} <= seed_b[3:0];
            serial_periph_enable <= seed[16];
            async_serial_enable <= seed[17];
            d_exp = {|seed_b[1:0], |seed_b[3:2], |seed_b[5:4], |seed_b[7:6], {4{seed[16]}}};
            // keypad_inputs trails a drive change by six edges
            repeat (7) @(posedge clk);
            @(negedge clk);
            chk("a_oe", ~seed[7:0], port_a_oe);
            chk("a_own", seed[7:0], port_a_periph_owned);
            chk("kp_in", (m[0] & ~seed[7:0]) | (pin[0] & seed[7:0]), keypad_inputs);
            chk("d_own", d_exp, port_d_periph_owned);
            chk("e_own", {6'h00, {2{seed[17]}}}, {6'h00, port_e_periph_owned});
            chk("b_oe", i < 8 ? ~(8'h01 << i) : 8'hff, port_b_oe);
            chk("b_an", i < 8 ? 8'h01 << i : 8'h00, port_b_analog);
            chk("d_oe", ~d_exp, port_d_oe);
            chk("e_oe", seed[17] ? 8'h00 : 8'h03, {6'h00, port_e_oe});
            @(posedge clk);
        end
        close_out;
    end
endmodule // parallel_io_ports_tb
`default_nettype wire
